// File: src/drm_pkg.sv
// constants, types and field layout of the dac register map and control block
// Function
// - address 0x01 loads the 16-bit data field into the output code register
// - 12-bit variant takes code from D15..D4 and ignores the low four bits
// - address 0x55 loads the full data field into the configuration register
// - overrange bit D14 widens the voltage output range by ten percent
// - bit D13 selects the external current setting resistor
// - outputs stay off unless D12 is set; range picks voltage or current
// - D4 enables slew control; rate in D11..D8, step in D7..D5
// - range field D2..D0 decodes to the listed voltage and current ranges
// - address 0x56 targets soft reset; only D0 matters
// - writing one to the reset bit restores the full power-on state
// - status register is read only; writes never change it
// - current output fault bit is set while a fault is seen
// - slewing bit is high while the output ramps, cleared when done
// - overtemperature bit is set above about 150 degrees
// - D15 ORed with clear-select pin picks the clear value
// - chain mode shifts surplus input bits out on serial data out
// - power-on reset loads zero in every register except the active-low serial data out enable, which loads one; outputs disabled
package drm_pkg;

    // ----------------------------------------------------------------
    // frame and addresses
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam logic [7:0] ADDR_NOP = 8'h00;
    localparam logic [7:0] ADDR_CODE = 8'h01;
    localparam logic [7:0] ADDR_READ = 8'h02;
    localparam logic [7:0] ADDR_CFG = 8'h55;
    localparam logic [7:0] ADDR_RST = 8'h56;
    localparam logic [1:0] RD_STATUS = 2'h0;
    localparam logic [1:0] RD_CODE = 2'h1;
    localparam logic [1:0] RD_CFG = 2'h2;

    // ----------------------------------------------------------------
    // reset values and bit positions
    // ----------------------------------------------------------------
    localparam logic [15:0] CODE_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam int SOFT_RST_BIT = 0;
    localparam int ST_CURRENT_OUTPUT_FAULT_BIT = 2;
    localparam int ST_SLEW_BIT = 1;
    localparam int ST_OVERTEMP_BIT = 0;

    // ----------------------------------------------------------------
    // slew timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEW_BASE_NS = 1000;
    localparam int SLEW_BASE_CYC = (SLEW_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RNG_V_0_5 = 3'b000,
        RNG_V_0_10 = 3'b001,
        RNG_V_PM5 = 3'b010,
        RNG_V_PM10 = 3'b011,
        RNG_UNLISTED = 3'b100,
        RNG_I_4_20 = 3'b101,
        RNG_I_0_20 = 3'b110,
        RNG_I_0_24 = 3'b111
    } drm_range_t;

    typedef struct packed {
        logic clear_value_select;
        logic overrange_enable;
        logic external_resistor_select;
        logic output_enable_bit;
        logic [3:0] slew_update_rate;
        logic [2:0] slew_increment;
        logic slew_control_enable;
        logic chain_mode_enable;
        drm_range_t range_select;
    } drm_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } drm_frame_t;

endpackage

// File: src/drm_shift_rx.sv
// serial shift receiver: sclk sampling, 24-bit frames, latch and data out
`timescale 1ns/1ns
module drm_shift_rx (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic sdin_i,
    input wire logic latch_i,
    input wire logic chain_i,
    input wire logic load_i,
    input wire logic [23:0] load_word_i,
    output drm_pkg::drm_frame_t frame_o,
    output logic frame_valid_o,
    output logic sdo_o
);
    import drm_pkg::*;

    logic [2:0] sync_m_q;
    logic [2:0] sync_s_q;
    logic sclk_d_q;
    logic latch_d_q;
    logic [23:0] sr_q;
    logic [5:0] cnt_q;
    logic sdo_q;
    logic valid_q;
    drm_frame_t frame_q;

    wire sclk_s = sync_s_q[0];
    wire sdin_s = sync_s_q[1];
    wire latch_s = sync_s_q[2];
    wire sclk_rise = sclk_s & ~sclk_d_q;
    wire sclk_fall = ~sclk_s & sclk_d_q;
    wire latch_rise = latch_s & ~latch_d_q;
    wire cnt_full = (cnt_q == 6'h3f);
    // exact count standalone, at least one frame in a chain
    wire len_ok = (cnt_q == 6'(FRAME_BITS)) | (chain_i & (cnt_q >= 6'(FRAME_BITS)));

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync_m_q <= 3'h0;
            sync_s_q <= 3'h0;
            sclk_d_q <= 1'b0;
            latch_d_q <= 1'b0;
        end else begin
            sync_m_q <= {latch_i, sdin_i, sclk_i};
            sync_s_q <= sync_m_q;
            sclk_d_q <= sclk_s;
            latch_d_q <= latch_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sr_q <= 24'h000000;
            cnt_q <= 6'h00;
            sdo_q <= 1'b0;
        end else if (load_i) begin
            sr_q <= load_word_i;
            sdo_q <= load_word_i[23];
        end else if (latch_rise) begin
            cnt_q <= 6'h00;
        end else if (sclk_rise) begin
            sr_q <= {sr_q[22:0], sdin_s};
            cnt_q <= cnt_full ? cnt_q : cnt_q + 6'h01;
        end else if (sclk_fall) begin
            sdo_q <= sr_q[23];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            valid_q <= 1'b0;
            frame_q <= '0;
        end else begin
            valid_q <= latch_rise & len_ok;
            frame_q <= sr_q;
        end
    end

    assign frame_o = frame_q;
    assign frame_valid_o = valid_q;
    assign sdo_o = sdo_q;

endmodule // drm_shift_rx

// File: src/drm_slew.sv
// digital slew engine: steps the output code toward its target
`timescale 1ns/1ns
module drm_slew #(
    parameter int W = 16,
    parameter int BASE_CYC = drm_pkg::SLEW_BASE_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] target_i,
    input wire logic enable_i,
    input wire logic [3:0] rate_i,
    input wire logic [2:0] step_i,
    output logic [W-1:0] code_o,
    output logic active_o
);
    import drm_pkg::*;

    logic [W-1:0] code_q;
    logic [W-1:0] code_d;
    logic active_q;
    logic [15:0] tmr_q;

    wire [15:0] period = 16'((32'(rate_i) + 32'd1) * 32'(BASE_CYC));
    wire tick = (tmr_q >= period - 16'h0001);
    wire [W-1:0] step = W'(1) << step_i;
    wire up = target_i > code_q;
    wire [W-1:0] gap = up ? target_i - code_q : code_q - target_i;
    wire [W-1:0] move = (gap < step) ? gap : step;

    always_comb begin
        code_d = code_q;
        if (!enable_i) begin
            code_d = target_i;
        end else if (tick) begin
            code_d = up ? code_q + move : code_q - move;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            code_q <= '0;
            active_q <= 1'b0;
            tmr_q <= 16'h0000;
        end else begin
            code_q <= code_d;
            active_q <= enable_i & (code_d != target_i);
            tmr_q <= (tick | !enable_i) ? 16'h0000 : tmr_q + 16'h0001;
        end
    end

    assign code_o = code_q;
    assign active_o = active_q;

endmodule // drm_slew

// File: src/drm_top.sv
// register map and control decode of a single channel dac
`timescale 1ns/1ns
module drm_top #(
    parameter int DAC_BITS = 16,
    parameter int SLEW_BASE = drm_pkg::SLEW_BASE_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic sdin_i,
    input wire logic latch_i,
    input wire logic clear_select_i,
    input wire logic current_output_fault_i,
    input wire logic overtemp_i,
    output logic [DAC_BITS-1:0] dac_code_o,
    output logic vout_enable_o,
    output logic iout_enable_o,
    output drm_pkg::drm_range_t range_o,
    output logic overrange_enable_o,
    output logic external_resistor_select_o,
    output logic clear_value_select_o,
    output logic [DAC_BITS-1:0] clear_code_o,
    output logic slew_active_o,
    output logic [15:0] fault_status_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_n_o
);
    import drm_pkg::*;

    // ----------------------------------------------------------------
    // constants at dac width, and the 16-bit code mask
    // ----------------------------------------------------------------
    localparam logic [DAC_BITS-1:0] ZERO_CODE = '0;
    localparam logic [DAC_BITS-1:0] MID_CODE = {1'b1, {(DAC_BITS-1){1'b0}}};
    localparam logic [15:0] CODE_MASK = 16'(16'hffff << (16 - DAC_BITS));

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic soft_rst_q;
    logic rst;
    logic [2:0] pin_m_q;
    logic [2:0] pin_s_q;
    logic [15:0] code_q;
    drm_cfg_t cfg_q;
    logic read_arm_q;
    logic [1:0] read_sel_q;
    logic load_q;
    logic [23:0] load_word_q;
    logic vout_en_q;
    logic iout_en_q;
    drm_range_t range_q;
    logic ovr_q;
    logic external_resistor_select_q;
    logic clr_sel_q;
    logic [DAC_BITS-1:0] clr_code_q;
    logic [15:0] status_q;
    logic sdo_oe_n_q;
    drm_frame_t frame;
    logic frame_valid;
    logic serial_data_out;
    logic [DAC_BITS-1:0] slew_code;
    logic slew_active;

    // ----------------------------------------------------------------
    // reset: pin reset or self-clearing soft reset
    // ----------------------------------------------------------------
    assign rst = srst_i | soft_rst_q;

    wire wr_code = frame_valid & (frame.addr == ADDR_CODE);
    wire wr_cfg = frame_valid & (frame.addr == ADDR_CFG);
    wire wr_rst = frame_valid & (frame.addr == ADDR_RST);
    wire wr_read = frame_valid & (frame.addr == ADDR_READ);
    wire rst_req = wr_rst & frame.data[SOFT_RST_BIT];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= rst_req;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers for analog monitor and clear-select inputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst) begin
            pin_m_q <= 3'h0;
            pin_s_q <= 3'h0;
        end else begin
            pin_m_q <= {clear_select_i, current_output_fault_i, overtemp_i};
            pin_s_q <= pin_m_q;
        end
    end

    wire clear_pin_s = pin_s_q[2];
    wire current_output_fault_s = pin_s_q[1];
    wire overtemp_s = pin_s_q[0];

    // ----------------------------------------------------------------
    // serial receiver
    // ----------------------------------------------------------------
    drm_shift_rx u_rx (
        .clk_i(clk_i),
        .srst_i(rst),
        .sclk_i(sclk_i),
        .sdin_i(sdin_i),
        .latch_i(latch_i),
        .chain_i(cfg_q.chain_mode_enable),
        .load_i(load_q),
        .load_word_i(load_word_q),
        .frame_o(frame),
        .frame_valid_o(frame_valid),
        .sdo_o(serial_data_out)
    );

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    // low bits of a narrow variant are don't care and stored as zero
    wire [15:0] code_wr = frame.data & CODE_MASK;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            code_q <= CODE_RST;
            cfg_q <= drm_cfg_t'(CFG_RST);
        end else begin
            if (wr_code) begin
                code_q <= code_wr;
            end
            if (wr_cfg) begin
                cfg_q <= drm_cfg_t'(frame.data);
            end
        end
    end

    // ----------------------------------------------------------------
    // slew engine
    // ----------------------------------------------------------------
    wire [DAC_BITS-1:0] code_target = code_q[15 -: DAC_BITS];

    drm_slew #(
        .W(DAC_BITS),
        .BASE_CYC(SLEW_BASE)
    ) u_slew (
        .clk_i(clk_i),
        .srst_i(rst),
        .target_i(code_target),
        .enable_i(cfg_q.slew_control_enable),
        .rate_i(cfg_q.slew_update_rate),
        .step_i(cfg_q.slew_increment),
        .code_o(slew_code),
        .active_o(slew_active)
    );

    // ----------------------------------------------------------------
    // output and range decode
    // ----------------------------------------------------------------
    wire [2:0] rng = cfg_q.range_select;
    wire rng_volt = ~rng[2];
    wire rng_curr = rng[2] & (rng[1:0] != 2'b00);
    wire rng_bipolar = rng_volt & rng[1];
    wire vout_en_d = cfg_q.output_enable_bit & rng_volt;
    wire iout_en_d = cfg_q.output_enable_bit & rng_curr;
    wire clr_sel_d = cfg_q.clear_value_select | clear_pin_s;
    wire [DAC_BITS-1:0] clr_volt = (clr_sel_d ^ rng_bipolar) ? MID_CODE : ZERO_CODE;
    // current output always clears to the bottom of its range
    wire [DAC_BITS-1:0] clr_code_d = rng_curr ? ZERO_CODE : clr_volt;

    // ----------------------------------------------------------------
    // status word, built from the monitor pins and the slew engine flag
    // ----------------------------------------------------------------
    logic [15:0] status_d;
    always_comb begin
        status_d = 16'h0000;
        status_d[ST_CURRENT_OUTPUT_FAULT_BIT] = current_output_fault_s;
        status_d[ST_SLEW_BIT] = slew_active;
        status_d[ST_OVERTEMP_BIT] = overtemp_s;
    end

    // ----------------------------------------------------------------
    // readback selection
    // ----------------------------------------------------------------
    wire [1:0] rd_sel_d = frame.data[1:0];
    // a read frame loads the register it names, not the one of the previous read
    wire [1:0] rd_sel = wr_read ? rd_sel_d : read_sel_q;
    wire [15:0] rd_word = (rd_sel == RD_STATUS) ? status_q :
                          (rd_sel == RD_CODE) ? code_q :
                          (rd_sel == RD_CFG) ? 16'(cfg_q) : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            read_arm_q <= 1'b0;
            read_sel_q <= RD_STATUS;
            load_q <= 1'b0;
            load_word_q <= 24'h000000;
        end else begin
            if (frame_valid) begin
                read_arm_q <= wr_read;
            end
            if (wr_read) begin
                read_sel_q <= rd_sel_d;
            end
            load_q <= wr_read;
            load_word_q <= {ADDR_NOP, rd_word};
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst) begin
            vout_en_q <= 1'b0;
            iout_en_q <= 1'b0;
            range_q <= RNG_V_0_5;
            ovr_q <= 1'b0;
            external_resistor_select_q <= 1'b0;
            clr_sel_q <= 1'b0;
            clr_code_q <= ZERO_CODE;
            status_q <= 16'h0000;
            sdo_oe_n_q <= 1'b1;
        end else begin
            vout_en_q <= vout_en_d;
            iout_en_q <= iout_en_d;
            range_q <= cfg_q.range_select;
            ovr_q <= cfg_q.overrange_enable & rng_volt;
            external_resistor_select_q <= cfg_q.external_resistor_select;
            clr_sel_q <= clr_sel_d;
            clr_code_q <= clr_code_d;
            status_q <= status_d;
            sdo_oe_n_q <= ~(cfg_q.chain_mode_enable | read_arm_q);
        end
    end

    assign dac_code_o = slew_code;
    assign vout_enable_o = vout_en_q;
    assign iout_enable_o = iout_en_q;
    assign range_o = range_q;
    assign overrange_enable_o = ovr_q;
    assign external_resistor_select_o = external_resistor_select_q;
    assign clear_value_select_o = clr_sel_q;
    assign clear_code_o = clr_code_q;
    assign slew_active_o = status_q[ST_SLEW_BIT];
    assign fault_status_o = status_q;
    assign serial_data_out_o = serial_data_out;
    assign serial_data_out_oe_n_o = sdo_oe_n_q;

endmodule // drm_top

// File: sim/drm_monitor.sv
// checker: port-level properties of the dac register map block
`timescale 1ns/1ns
module drm_monitor
    import drm_pkg::*;
#(
    parameter int DAC_BITS = 16,
    parameter int SLEW_BASE = drm_pkg::SLEW_BASE_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic sdin_i,
    input wire logic latch_i,
    input wire logic clear_select_i,
    input wire logic current_output_fault_i,
    input wire logic overtemp_i,
    input wire logic [DAC_BITS-1:0] dac_code_o,
    input wire logic vout_enable_o,
    input wire logic iout_enable_o,
    input wire drm_pkg::drm_range_t range_o,
    input wire logic overrange_enable_o,
    input wire logic external_resistor_select_o,
    input wire logic clear_value_select_o,
    input wire logic [DAC_BITS-1:0] clear_code_o,
    input wire logic slew_active_o,
    input wire logic [15:0] fault_status_o,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    reserved_zero_a: assert property (fault_status_o[15:3] == 13'h0000)
        else $error("status upper bits not zero");
    slew_flag_a: assert property ($fell(slew_active_o) |-> $stable(dac_code_o) ||
        dac_code_o == '0) else $error("slew flag cleared while code still moving");
    one_output_a: assert property (!(vout_enable_o && iout_enable_o))
        else $error("both outputs enabled");
    vout_range_a: assert property (vout_enable_o |-> !range_o[2])
        else $error("voltage output on with current range");
    iout_range_a: assert property (iout_enable_o |-> range_o[2] && range_o != RNG_UNLISTED)
        else $error("current output on without current range");
    overrange_volt_a: assert property (overrange_enable_o |-> !range_o[2])
        else $error("overrange on a current range");
    fault_track_a: assert property ($stable(current_output_fault_i) [*6] |->
        fault_status_o[2] == current_output_fault_i) else $error("fault bit does not follow monitor");
    overtemp_track_a: assert property ($stable(overtemp_i) [*6] |->
        fault_status_o[0] == overtemp_i) else $error("overtemp bit does not follow monitor");
    clear_pin_a: assert property (clear_select_i [*6] |-> clear_value_select_o)
        else $error("clear select pin not seen");
    reset_state_a: assert property (disable iff (1'b0) srst_i |=> !vout_enable_o &&
        !iout_enable_o && dac_code_o == '0 && fault_status_o == 16'h0000 &&
        serial_data_out_oe_n_o) else $error("state not cleared by reset");
endmodule // drm_monitor

bind drm_top drm_monitor #(.DAC_BITS(DAC_BITS), .SLEW_BASE(SLEW_BASE)) u_drm_monitor (
    .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .sdin_i(sdin_i), .latch_i(latch_i),
    .clear_select_i(clear_select_i), .current_output_fault_i(current_output_fault_i), .overtemp_i(overtemp_i),
    .dac_code_o(dac_code_o), .vout_enable_o(vout_enable_o), .iout_enable_o(iout_enable_o),
    .range_o(range_o), .overrange_enable_o(overrange_enable_o),
    .external_resistor_select_o(external_resistor_select_o),
    .clear_value_select_o(clear_value_select_o), .clear_code_o(clear_code_o),
    .slew_active_o(slew_active_o), .fault_status_o(fault_status_o),
    .serial_data_out_o(serial_data_out_o), .serial_data_out_oe_n_o(serial_data_out_oe_n_o)
);

// File: sim/drm_host_model.sv
// host model: drives the serial link and captures the serial data line
`timescale 1ns/1ns
module drm_host_model (
    input wire logic clk_i,
    input wire logic ser_i,
    output logic sclk_o,
    output logic sdin_o,
    output logic latch_o,
    output logic [23:0] rx_o
);
    initial begin
        sclk_o = 1'b0;
        sdin_o = 1'b0;
        latch_o = 1'b0;
        rx_o = 24'h000000;
    end

    // 40 ns half period of the 80 ns link clock
    task automatic half_period();
        repeat (4) @(negedge clk_i);
    endtask

    // link clock stands low between frames
    task automatic send_frame(input logic [23:0] word, input int nbits);
        for (int i = nbits - 1; i >= 0; i--) begin
            sdin_o = word[i % 24];
            half_period();
            sclk_o = 1'b1;
            half_period();
            rx_o = {rx_o[22:0], ser_i};
            sclk_o = 1'b0;
        end
        sdin_o = ~sdin_o;
        half_period();
        latch_o = 1'b1;
        half_period();
        latch_o = 1'b0;
        repeat (16) @(negedge clk_i);
    endtask
endmodule // drm_host_model

// File: sim/tb_drm_top.sv
// testbench: serial register writes, readback and output decode
`timescale 1ns/1ns
module tb_drm_top;
    import drm_pkg::*;
    logic clk_i, srst_i, clear_select_i, current_output_fault_i, overtemp_i;
    wire sclk, sdin, latch, ser_line;
    wire [23:0] rx_word;
    logic [15:0] dac_code, clear_code, fault_status, cfg;
    logic [11:0] narrow_code;
    logic vout_en, iout_en, ovr_en, ext_res, clr_sel, slew_act, ser_out, ser_oe_n;
    drm_range_t range;
    int fail_count, tests_run;
    logic [2:0] rngs [3] = '{3'h0, 3'h2, 3'h5};

    assign ser_line = ser_oe_n ? 1'bz : ser_out;

    drm_top #(.DAC_BITS(16), .SLEW_BASE(2)) u_drm_top (
        .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .sdin_i(sdin), .latch_i(latch),
        .clear_select_i(clear_select_i), .current_output_fault_i(current_output_fault_i), .overtemp_i(overtemp_i),
        .dac_code_o(dac_code), .vout_enable_o(vout_en), .iout_enable_o(iout_en),
        .range_o(range), .overrange_enable_o(ovr_en), .external_resistor_select_o(ext_res),
        .clear_value_select_o(clr_sel), .clear_code_o(clear_code), .slew_active_o(slew_act),
        .fault_status_o(fault_status), .serial_data_out_o(ser_out),
        .serial_data_out_oe_n_o(ser_oe_n)
    );
    drm_top #(.DAC_BITS(12), .SLEW_BASE(2)) u_drm_top_narrow (
        .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .sdin_i(sdin), .latch_i(latch),
        .clear_select_i(clear_select_i), .current_output_fault_i(current_output_fault_i), .overtemp_i(overtemp_i),
        .dac_code_o(narrow_code), .vout_enable_o(), .iout_enable_o(), .range_o(),
        .overrange_enable_o(), .external_resistor_select_o(), .clear_value_select_o(),
        .clear_code_o(), .slew_active_o(), .fault_status_o(), .serial_data_out_o(),
        .serial_data_out_oe_n_o()
    );
    drm_host_model u_drm_host_model (
        .clk_i(clk_i), .ser_i(ser_line), .sclk_o(sclk), .sdin_o(sdin), .latch_o(latch),
        .rx_o(rx_word)
    );

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [23:0] word);
        u_drm_host_model.send_frame(word, 24);
    endtask
    task automatic rd(input logic [1:0] sel, output logic [23:0] word);
        wr({ADDR_READ, 14'h0000, sel});
        wr({ADDR_NOP, 16'h0000});
        word = rx_word;
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        logic [23:0] word;
        int n;
        srst_i = 1'b1;
        clear_select_i = 1'b0;
        current_output_fault_i = 1'b0;
        overtemp_i = 1'b0;
        fail_count = 0;
        tests_run = 0;
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        check("code", dac_code, 24'h0);
        check("enables", {vout_en, iout_en, ser_oe_n}, 24'h1);
        for (int r = 0; r < 8; r++) begin
            wr({ADDR_CFG, 16'h7000 | 16'(r)});
            check("vout", vout_en, 24'(r < 4));
            check("iout", iout_en, 24'(r > 4));
            check("range", range, 24'(r));
            check("overrange", ovr_en, 24'(r < 4));
            check("ext res", ext_res, 24'h1);
        end
        rd(RD_CFG, word);
        check("cfg read", word, 24'h007007);
        wr({ADDR_CFG, 16'h0005});
        check("disabled", {vout_en, iout_en}, 24'h0);
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 3; k++) begin
                clear_select_i = (s == 2);
                cfg = 16'h1000 | 16'(rngs[k]);
                cfg[15] = (s == 1);
                wr({ADDR_CFG, cfg});
                check("clear sel", clr_sel, 24'(s != 0));
                check("clear code", clear_code, (!rngs[k][2] && ((rngs[k] == 3'h2) ^ (s != 0)))
                    ? 24'h008000 : 24'h0);
            end
        end
        clear_select_i = 1'b0;
        wr({ADDR_CODE, 16'habcd});
        check("code", dac_code, 24'h00abcd);
        check("narrow code", narrow_code, 24'h000abc);
        rd(RD_CODE, word);
        check("code read", word, 24'h00abcd);
        current_output_fault_i = 1'b1;
        overtemp_i = 1'b1;
        repeat (10) @(negedge clk_i);
        check("status", fault_status, 24'h5);
        rd(RD_STATUS, word);
        check("status read", word, 24'h5);
        u_drm_host_model.send_frame(24'h011111, 23);
        u_drm_host_model.send_frame(24'h011111, 25);
        wr(24'h331111);
        wr({ADDR_RST, 16'hfffe});
        check("code kept", dac_code, 24'h00abcd);
        check("status kept", fault_status, 24'h5);
        rd(RD_CFG, word);
        check("cfg kept", word, 24'h001005);
        current_output_fault_i = 1'b0;
        overtemp_i = 1'b0;
        repeat (10) @(negedge clk_i);
        check("status clear", fault_status, 24'h0);
        wr({ADDR_CODE, 16'h0000});
        wr({ADDR_CFG, 16'h1010});
        wr({ADDR_CODE, 16'h0040});
        check("slewing", {slew_act, fault_status[1]}, 24'h3);
        n = 0;
        while (slew_act === 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 400) begin
            check("slew end", 24'h1, 24'h0);
            report_and_stop();
        end
        check("slew code", dac_code, 24'h000040);
        check("slew done", fault_status[1], 24'h0);
        wr({ADDR_CFG, 16'h0008});
        wr(24'h011234);
        check("chain drive", ser_oe_n, 24'h0);
        wr({ADDR_NOP, 16'h0000});
        check("chain out", rx_word, 24'h011234);
        wr({ADDR_RST, 16'h0001});
        check("reset code", dac_code, 24'h0);
        check("reset state", {vout_en, iout_en, ser_oe_n, range}, 24'h8);
        rd(RD_CFG, word);
        check("reset cfg", word, 24'h0);
        report_and_stop();
    end
endmodule // tb_drm_top
